//--- gpe_pkg.sv
// Constants for the three-port GPIO block with edge interrupts
package gpe_pkg;

   // ----------------------------------------------------------------
   // Pin layout
   // ----------------------------------------------------------------
   localparam int PIN_COUNT = 21;
   localparam int PORT1_LSB = 8;
   localparam int PORT2_LSB = 16;
   localparam int PORT2_WIDTH = 5;
   localparam logic [20:0] NO_PULL_MASK = 21'h000300;
   localparam logic [20:0] RESET_PULL_MASK = 21'h040000;
   localparam logic [20:0] AUDIO_PIN_MASK = 21'h00C003;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_FIRST_PORT = 8'h00;
   localparam logic [7:0] OFS_SECOND_PORT = 8'h04;
   localparam logic [7:0] OFS_THIRD_PORT = 8'h08;
   localparam logic [7:0] OFS_FUNC_SEL = 8'h0C;
   localparam logic [7:0] OFS_DIRECTION = 8'h10;
   localparam logic [7:0] OFS_PULL_DIS = 8'h14;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'h18;
   localparam logic [7:0] OFS_P1_BIT_EN = 8'h1C;
   localparam logic [7:0] OFS_PIN_FLAGS = 8'h20;
   localparam logic [7:0] OFS_CPU_EN = 8'h24;
   localparam logic [7:0] OFS_CPU_FLAGS = 8'h28;
   localparam logic [7:0] OFS_POWER_CTRL = 8'h2C;
   localparam logic [7:0] OFS_BIT_OP = 8'h30;
   localparam logic [7:0] OFS_LATCH = 8'h34;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int IRQ_LOW_EN_BIT = 0;
   localparam int IRQ_HIGH_EN_BIT = 1;
   localparam int IRQ_P2_EN_BIT = 2;
   localparam int IRQ_EDGE_LSB = 3;
   localparam int PWR_AUDIO_BIT = 2;
   localparam int PWR_PDSEL_LSB = 3;
   localparam int BIT_OP_VALUE_BIT = 8;
   localparam logic [20:0] FUNC_SEL_RESET = 21'h000000;
   localparam logic [20:0] DIRECTION_RESET = 21'h000000;
   localparam logic [20:0] PULL_DIS_RESET = 21'h000000;
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpe_pkg

//--- gpe_gpio_ports.sv
// Three-port GPIO with pull control, retention, edge flags and AXI4-Lite registers
`timescale 1ns/1ps

// How it works
// - Two eight-bit ports, one five-bit port
// - Per-pin function select, GPIO after reset
// - Audio serial enable claims its pins
// - Direction bit 1 is output, inputs after reset
// - Port read returns pin levels
// - Bit operation modifies latch, not pins
// - Inputs pull up, down or float
// - Pull disable bit leaves input floating
// - Second port bits zero, one unpulled
// - Power modes one to three freeze pins
// - Only third port bit two pulled in reset
// - Only GPIO inputs raise pin events
// - Rising or falling edge selectable
// - One CPU enable per port
// - Second port has per-bit enables
// - First port has nibble enables
// - Third port has one shared enable
// - Edge sets status flag regardless of enable
// - CPU flag needs a relevant enable set
// - Enabled pin events wake from every power mode
// - Port interrupts blocked unless mode zero
module gpe_gpio_ports (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [gpe_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [gpe_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] pin_in,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] periph_out,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] periph_drive,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] audio_out,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] audio_drive,
   output logic [gpe_pkg::PIN_COUNT-1:0] pin_out,
   output logic [gpe_pkg::PIN_COUNT-1:0] pin_oe_n,
   output logic [gpe_pkg::PIN_COUNT-1:0] pin_pull_up,
   output logic [gpe_pkg::PIN_COUNT-1:0] pin_pull_down,
   output logic [2:0] port_irq,
   output logic wake
);
   import gpe_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [20:0] latch;
      logic [20:0] func_sel;
      logic [20:0] direction;
      logic [20:0] pull_dis;
      logic [20:0] flags;
      logic [20:0] sync1;
      logic [20:0] sync2;
      logic [20:0] sync3;
      logic [20:0] pout;
      logic [20:0] poe_n;
      logic [20:0] pup;
      logic [20:0] pdn;
      logic [7:0] p1_bit_en;
      logic [5:0] irq_ctrl;
      logic [2:0] cpu_en;
      logic [2:0] cpu_flags;
      logic [2:0] irq;
      logic [5:0] power_ctrl;
      logic wake;
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } gpe_state_type;

   gpe_state_type q;
   gpe_state_type d;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic reg_known(input logic [7:0] a);
      case (a)
         OFS_FIRST_PORT, OFS_SECOND_PORT, OFS_THIRD_PORT, OFS_FUNC_SEL,
         OFS_DIRECTION, OFS_PULL_DIS, OFS_IRQ_CTRL, OFS_P1_BIT_EN,
         OFS_PIN_FLAGS, OFS_CPU_EN, OFS_CPU_FLAGS, OFS_POWER_CTRL,
         OFS_BIT_OP, OFS_LATCH: reg_known = 1'b1;
         default: reg_known = 1'b0;
      endcase
   endfunction : reg_known

   function automatic logic [31:0] byte_mask(input logic [3:0] s);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{s[b]}};
      end
      byte_mask = m;
   endfunction : byte_mask

   function automatic logic [1:0] port_of(input int i);
      port_of = (i < PORT1_LSB) ? 2'h0 : (i < PORT2_LSB) ? 2'h1 : 2'h2;
   endfunction : port_of

   // ----------------------------------------------------------------
   // Pin events
   // ----------------------------------------------------------------
   logic mode_active;
   logic [20:0] audio_claim;
   logic [20:0] gp_input;
   logic [20:0] rise;
   logic [20:0] fall;
   logic [20:0] pin_event;
   logic [20:0] pin_enable;
   logic [20:0] hit;
   logic [2:0] port_hit;

   assign mode_active = (q.power_ctrl[1:0] == MODE_ACTIVE);
   assign audio_claim = q.power_ctrl[PWR_AUDIO_BIT] ? AUDIO_PIN_MASK : 21'h000000;
   assign gp_input = ~q.func_sel & ~q.direction & ~audio_claim;
   assign rise = q.sync2 & ~q.sync3;
   assign fall = ~q.sync2 & q.sync3;

   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++) begin : g_pin
         localparam logic [1:0] PORT = port_of(g);
         // Edge choice per port, rising when clear
         assign pin_event[g] = (q.irq_ctrl[IRQ_EDGE_LSB + PORT] ? fall[g] : rise[g])
                               & gp_input[g];
         if (g < 4) begin : g_low
            assign pin_enable[g] = q.irq_ctrl[IRQ_LOW_EN_BIT];
         end else if (g < PORT1_LSB) begin : g_high
            assign pin_enable[g] = q.irq_ctrl[IRQ_HIGH_EN_BIT];
         end else if (g < PORT2_LSB) begin : g_p1
            assign pin_enable[g] = q.p1_bit_en[g - PORT1_LSB];
         end else begin : g_p2
            assign pin_enable[g] = q.irq_ctrl[IRQ_P2_EN_BIT];
         end
      end
   endgenerate

   assign hit = pin_event & pin_enable;
   assign port_hit = {|hit[20:16], |hit[15:8], |hit[7:0]};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] be;
      logic [31:0] wm;
      logic [20:0] flag_clr;
      logic [2:0] cpu_clr;
      logic drive;
      logic value;
      logic pull_on;
      logic [4:0] bit_idx;
      be = byte_mask(q.w_strb);
      wm = 32'h0000_0000;
      flag_clr = 21'h000000;
      cpu_clr = 3'h0;
      drive = 1'b0;
      value = 1'b0;
      pull_on = 1'b0;
      bit_idx = q.w_data[4:0];
      d = q;
      // Synchroniser, first stage read only by the second
      d.sync1 = pin_in;
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      // Write channel
      if (s_axi_awvalid && q.awready) begin
         d.aw_full = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_full = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.aw_full && q.w_full && !q.bvalid) begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = reg_known(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         case (q.aw_addr)
            OFS_FIRST_PORT: begin
               wm = ({11'h000, q.latch} & ~be) | (q.w_data & be);
               d.latch[7:0] = wm[7:0];
            end
            OFS_SECOND_PORT: begin
               wm = ({11'h000, q.latch} & ~be) | ((q.w_data << PORT1_LSB) & be);
               d.latch[15:8] = q.w_strb[0] ? q.w_data[7:0] : q.latch[15:8];
            end
            OFS_THIRD_PORT: begin
               if (q.w_strb[0]) begin
                  d.latch[20:16] = q.w_data[PORT2_WIDTH-1:0];
               end
            end
            OFS_FUNC_SEL: begin
               wm = ({11'h000, q.func_sel} & ~be) | (q.w_data & be);
               d.func_sel = wm[20:0];
            end
            OFS_DIRECTION: begin
               wm = ({11'h000, q.direction} & ~be) | (q.w_data & be);
               d.direction = wm[20:0];
            end
            OFS_PULL_DIS: begin
               wm = ({11'h000, q.pull_dis} & ~be) | (q.w_data & be);
               d.pull_dis = wm[20:0];
            end
            OFS_IRQ_CTRL: begin
               if (q.w_strb[0]) begin
                  d.irq_ctrl = q.w_data[5:0];
               end
            end
            OFS_P1_BIT_EN: begin
               if (q.w_strb[0]) begin
                  d.p1_bit_en = q.w_data[7:0];
               end
            end
            OFS_PIN_FLAGS: begin
               flag_clr = q.w_data[20:0] & be[20:0];
            end
            OFS_CPU_EN: begin
               if (q.w_strb[0]) begin
                  d.cpu_en = q.w_data[2:0];
               end
            end
            OFS_CPU_FLAGS: begin
               cpu_clr = q.w_data[2:0] & be[2:0];
            end
            OFS_POWER_CTRL: begin
               if (q.w_strb[0]) begin
                  d.power_ctrl = q.w_data[5:0];
               end
            end
            OFS_BIT_OP: begin
               // Read-modify-write of one bit works on the latch
               if (q.w_strb[0] && bit_idx < 5'(PIN_COUNT)) begin
                  d.latch[bit_idx] = q.w_data[BIT_OP_VALUE_BIT];
               end
            end
            default: begin
               wm = 32'h0000_0000;
            end
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      d.awready = !d.aw_full && !d.bvalid;
      d.wready = !d.w_full && !d.bvalid;
      // Read channel
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_FIRST_PORT: d.rdata = {24'h000000, q.sync2[7:0]};
            OFS_SECOND_PORT: d.rdata = {24'h000000, q.sync2[15:8]};
            OFS_THIRD_PORT: d.rdata = {27'h0000000, q.sync2[20:16]};
            OFS_FUNC_SEL: d.rdata = {11'h000, q.func_sel};
            OFS_DIRECTION: d.rdata = {11'h000, q.direction};
            OFS_PULL_DIS: d.rdata = {11'h000, q.pull_dis};
            OFS_IRQ_CTRL: d.rdata = {26'h0000000, q.irq_ctrl};
            OFS_P1_BIT_EN: d.rdata = {24'h000000, q.p1_bit_en};
            OFS_PIN_FLAGS: d.rdata = {11'h000, q.flags};
            OFS_CPU_EN: d.rdata = {29'h00000000, q.cpu_en};
            OFS_CPU_FLAGS: d.rdata = {29'h00000000, q.cpu_flags};
            OFS_POWER_CTRL: d.rdata = {26'h0000000, q.power_ctrl};
            OFS_LATCH: d.rdata = {11'h000, q.latch};
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      d.arready = !d.rvalid;
      // Flags: a new edge beats a clear in the same cycle
      d.flags = (q.flags & ~flag_clr) | pin_event;
      d.cpu_flags = (q.cpu_flags & ~cpu_clr) | (mode_active ? port_hit : 3'h0);
      d.irq = q.cpu_flags & q.cpu_en;
      d.wake = |port_hit;
      // Enabled event in a low-power mode returns to active
      if (|port_hit && !mode_active) begin
         d.power_ctrl[1:0] = MODE_ACTIVE;
      end
      // Pad control, frozen while in a low-power mode
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (audio_claim[i]) begin
            drive = audio_drive[i];
            value = audio_out[i];
         end else if (q.func_sel[i]) begin
            drive = periph_drive[i];
            value = periph_out[i];
         end else begin
            drive = q.direction[i];
            value = q.latch[i];
         end
         pull_on = !drive && !q.pull_dis[i] && !NO_PULL_MASK[i];
         if (mode_active) begin
            d.pout[i] = value;
            d.poe_n[i] = !drive;
            d.pup[i] = pull_on && !q.power_ctrl[PWR_PDSEL_LSB + port_of(i)];
            d.pdn[i] = pull_on && q.power_ctrl[PWR_PDSEL_LSB + port_of(i)];
         end
      end
      if (!aresetn) begin
         d = '0;
         d.func_sel = FUNC_SEL_RESET;
         d.direction = DIRECTION_RESET;
         d.pull_dis = PULL_DIS_RESET;
         d.poe_n = '1;
         d.pup = RESET_PULL_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      q <= d;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign pin_out = q.pout;
   assign pin_oe_n = q.poe_n;
   assign pin_pull_up = q.pup;
   assign pin_pull_down = q.pdn;
   assign port_irq = q.irq;
   assign wake = q.wake;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_first_port_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_FIRST_PORT;
   endsequence
   sequence s_sleep_event;
      (|port_hit) && !mode_active;
   endsequence

   a_flag_on_edge: assert property (
      (|pin_event) |=> ((q.flags & $past(pin_event)) == $past(pin_event)))
      else $error("pin edge did not set its status flag");
   a_reset_pull: assert property (disable iff (1'b0)
      !aresetn |=> (pin_pull_up == RESET_PULL_MASK && pin_pull_down == '0))
      else $error("wrong pulls during reset");
   a_no_pull_pins: assert property (
      ((pin_pull_up | pin_pull_down) & NO_PULL_MASK) == '0)
      else $error("unpulled pins show a pull");
   a_retain_pins: assert property (
      !mode_active && $past(!mode_active) |-> $stable(pin_out) && $stable(pin_oe_n))
      else $error("pins changed in a low-power mode");
   a_read_levels: assert property (
      s_first_port_read |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(q.sync2[7:0]))
      else $error("port read did not return pin levels");
   a_sync_delay: assert property (
      $past(aresetn, 3) |-> q.sync2 == $past(pin_in, 2))
      else $error("synchroniser delay is not two cycles");
   a_cpu_flag_cause: assert property (
      $rose(q.cpu_flags[1]) |-> $past(port_hit[1]) && $past(mode_active))
      else $error("CPU flag rose without an enabled event");
   a_sleep_blocks: assert property (
      !mode_active |=> (q.cpu_flags & ~$past(q.cpu_flags)) == 3'h0)
      else $error("port interrupt passed in a low-power mode");
   a_wake_event: assert property (
      s_sleep_event |=> wake && q.power_ctrl[1:0] == MODE_ACTIVE)
      else $error("enabled pin event did not wake");
   a_output_dir: assert property (
      mode_active && q.direction[2] && !q.func_sel[2] |=> !pin_oe_n[2])
      else $error("output pin is not driven");

endmodule : gpe_gpio_ports

//--- gpe_pin_partner.sv
// External pin model: device drive, outside drivers, pulls and floating lines
`timescale 1ns/1ps
module gpe_pin_partner (
   input wire logic aclk,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] pin_out,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] pin_oe_n,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] pull_up,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] pull_down,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] ext_en,
   input wire logic [gpe_pkg::PIN_COUNT-1:0] ext_val,
   output logic [gpe_pkg::PIN_COUNT-1:0] pin_level
);
   import gpe_pkg::*;
   // ----------------------------------------------------------------
   // Pin resolution
   // ----------------------------------------------------------------
   logic [PIN_COUNT-1:0] float_q = '0;
   // Unpulled, undriven lines wander so a stale level never reads as valid
   always @(posedge aclk) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
         else if (ext_en[i]) pin_level[i] = ext_val[i];
         else if (pull_up[i]) pin_level[i] = 1'b1;
         else if (pull_down[i]) pin_level[i] = 1'b0;
         else pin_level[i] = float_q[i];
      end
   end
endmodule : gpe_pin_partner

//--- gpe_gpio_ports_tb.sv
// Self-checking bench for the three-port GPIO block
`timescale 1ns/1ps
module gpe_gpio_ports_tb;
   import gpe_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [PIN_COUNT-1:0] pin_in, periph_out, periph_drive, audio_out, audio_drive, ext_en;
   logic [PIN_COUNT-1:0] pin_out, pin_oe_n, pin_pull_up, pin_pull_down, ext_val;
   logic [2:0] port_irq;
   logic wake;
   int bad_count = 0;
   int total_checks = 0;
   int wake_seen = 0;

   gpe_gpio_ports DUT (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pin_in, .periph_out, .periph_drive, .audio_out,
      .audio_drive, .pin_out, .pin_oe_n, .pin_pull_up, .pin_pull_down, .port_irq, .wake
   );
   gpe_pin_partner PARTNER (
      .aclk, .pin_out, .pin_oe_n, .pull_up(pin_pull_up), .pull_down(pin_pull_down),
      .ext_en, .ext_val, .pin_level(pin_in)
   );

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (wake === 1'b1) wake_seen++;
   end
   // ----------------------------------------------------------------
   // Common tasks
   // ----------------------------------------------------------------
   task automatic results();
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic guard(inout int n);
      n++;
      if (n > 200) begin
         bad_count++;
         $display("CHECK FAILED %0t bus wait ran out", $time);
         results();
      end
   endtask : guard
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : wait_cyc
   task automatic pin(input int i, input logic v);
      @(posedge aclk);
      ext_val[i] <= v;
   endtask : pin
   // Master holds each channel until its own ready; response read at the same edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         guard(n);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         guard(n);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : axi_rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, rsp);
      chk(rsp, RESP_OKAY);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      axi_rd(a, rd, rsp);
      chk(rsp, RESP_OKAY);
      chk(rd & m, e);
   endtask : rdc
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic sc_reset();
      @(posedge aclk);
      #1;
      chk(pin_pull_up, RESET_PULL_MASK);
      chk(pin_oe_n, 21'h1FFFFF);
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wait_cyc(2);
      chk(pin_pull_up, 21'(~NO_PULL_MASK));
      chk(pin_pull_down, 21'h0);
      rdc(OFS_FUNC_SEL, 32'hFFFFFFFF, 32'h0);
      rdc(OFS_DIRECTION, 32'hFFFFFFFF, 32'h0);
      rdc(OFS_PULL_DIS, 32'hFFFFFFFF, 32'h0);
      axi_rd(8'h3C, rd, rsp);
      chk(rsp, RESP_SLVERR);
      axi_wr(8'h3C, 32'h1, rsp);
      chk(rsp, RESP_SLVERR);
   endtask : sc_reset
   task automatic sc_ports();
      wr(OFS_FIRST_PORT, 32'hA5);
      wr(OFS_DIRECTION, 32'hFF);
      wait_cyc(2);
      chk(pin_oe_n[7:0], 8'h00);
      chk(pin_out[7:0], 8'hA5);
      pin(8, 1'b1);
      wait_cyc(4);
      rdc(OFS_FIRST_PORT, 32'hFF, 32'hA5);
      rdc(OFS_SECOND_PORT, 32'hFF, 32'h01);
      // Pin 8 is high but its latch bit must stay low
      wr(OFS_BIT_OP, (32'h1 << BIT_OP_VALUE_BIT) | 32'd9);
      rdc(OFS_LATCH, 32'h3FF, 32'h2A5);
      wr(OFS_SECOND_PORT, 32'h5A);
      wr(OFS_THIRD_PORT, 32'h13);
      rdc(OFS_LATCH, 32'h1FFF00, 32'h135A00);
      wr(OFS_PULL_DIS, 32'h400);
      wr(OFS_POWER_CTRL, 32'h1 << (PWR_PDSEL_LSB + 1));
      wait_cyc(2);
      chk(pin_pull_down[15:8], 8'hF8);
      chk(pin_pull_up[15:8], 8'h00);
      chk(pin_pull_up[20:16], 5'h1F);
   endtask : sc_ports
   task automatic sc_func();
      @(posedge aclk);
      periph_drive <= '1;
      periph_out <= '1;
      audio_drive <= '1;
      audio_out <= '1;
      wr(OFS_FUNC_SEL, 32'h10000);
      wait_cyc(2);
      chk(pin_oe_n[16], 1'b0);
      wr(OFS_POWER_CTRL, 32'h1 << PWR_AUDIO_BIT);
      wait_cyc(2);
      chk(pin_oe_n & AUDIO_PIN_MASK, 32'h0);
      chk(pin_out & AUDIO_PIN_MASK, AUDIO_PIN_MASK);
      wr(OFS_POWER_CTRL, 32'h0);
      wr(OFS_FUNC_SEL, 32'h0);
      wr(OFS_DIRECTION, 32'h1);
      wait_cyc(4);
      chk(pin_oe_n[16], 1'b1);
   endtask : sc_func
   task automatic sc_irq();
      wr(OFS_PIN_FLAGS, 32'h1FFFFF);
      wr(OFS_CPU_FLAGS, 32'h7);
      wr(OFS_IRQ_CTRL, 32'h1 << IRQ_LOW_EN_BIT);
      wr(OFS_CPU_EN, 32'h7);
      // Rising edge on an output pin must stay silent
      wr(OFS_BIT_OP, 32'h0);
      wr(OFS_BIT_OP, 32'h1 << BIT_OP_VALUE_BIT);
      pin(5, 1'b1);
      wait_cyc(6);
      rdc(OFS_PIN_FLAGS, 32'hFF, 32'h20);
      rdc(OFS_CPU_FLAGS, 32'h7, 32'h0);
      pin(2, 1'b1);
      wait_cyc(6);
      rdc(OFS_PIN_FLAGS, 32'hFF, 32'h24);
      rdc(OFS_CPU_FLAGS, 32'h7, 32'h1);
      chk(port_irq, 3'h1);
      wr(OFS_PIN_FLAGS, 32'hFF);
      wr(OFS_CPU_FLAGS, 32'h1);
      wait_cyc(4);
      rdc(OFS_PIN_FLAGS, 32'hFF, 32'h0);
      chk(port_irq, 3'h0);
      wr(OFS_CPU_EN, 32'h6);
      wr(OFS_IRQ_CTRL, (32'h1 << IRQ_LOW_EN_BIT) | (32'h1 << IRQ_EDGE_LSB));
      pin(3, 1'b1);
      pin(2, 1'b0);
      wait_cyc(6);
      rdc(OFS_PIN_FLAGS, 32'hFF, 32'h04);
      rdc(OFS_CPU_FLAGS, 32'h7, 32'h1);
      chk(port_irq, 3'h0);
      wr(OFS_P1_BIT_EN, 32'h18);
      pin(10, 1'b1);
      wait_cyc(6);
      rdc(OFS_CPU_FLAGS, 32'h2, 32'h0);
      pin(11, 1'b1);
      wait_cyc(6);
      rdc(OFS_CPU_FLAGS, 32'h2, 32'h2);
      chk(port_irq[1], 1'b1);
      wr(OFS_IRQ_CTRL, 32'h1 << IRQ_P2_EN_BIT);
      pin(20, 1'b1);
      wait_cyc(6);
      rdc(OFS_CPU_FLAGS, 32'h4, 32'h4);
      rdc(OFS_THIRD_PORT, 32'hFFFFFFFF, 32'h10);
      chk(port_irq[2], 1'b1);
      wr(OFS_IRQ_CTRL, (32'h1 << IRQ_P2_EN_BIT) | (32'h1 << (IRQ_EDGE_LSB + 2)));
      wr(OFS_PIN_FLAGS, 32'h100000);
      wr(OFS_CPU_FLAGS, 32'h4);
      rdc(OFS_CPU_FLAGS, 32'h4, 32'h0);
      pin(20, 1'b0);
      wait_cyc(6);
      rdc(OFS_CPU_FLAGS, 32'h4, 32'h4);
   endtask : sc_irq
   task automatic sc_sleep();
      int w0;
      wr(OFS_PIN_FLAGS, 32'h1FFFFF);
      wr(OFS_CPU_FLAGS, 32'h7);
      wr(OFS_POWER_CTRL, 32'h1);
      wr(OFS_DIRECTION, 32'h3);
      wait_cyc(2);
      chk(pin_oe_n[1], 1'b1);
      w0 = wake_seen;
      pin(12, 1'b1);
      wait_cyc(6);
      chk(wake_seen - w0, 32'd1);
      chk(pin_oe_n[1], 1'b0);
      rdc(OFS_CPU_FLAGS, 32'h7, 32'h0);
      rdc(OFS_PIN_FLAGS, 32'h1000, 32'h1000);
      rdc(OFS_POWER_CTRL, 32'h3, 32'h0);
   endtask : sc_sleep

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      {periph_out, periph_drive, audio_out, audio_drive, ext_val} = '0;
      ext_en = '1;
      sc_reset();
      sc_ports();
      sc_func();
      sc_irq();
      sc_sleep();
      results();
   end
endmodule : gpe_gpio_ports_tb
